// file: pfc_pkg.sv
// Shared constants and types of the parallel flash command controller.
package pfc_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int WB_ADR_W = 8;
  localparam int CNT_W = 8;
  // Own register map, byte addresses on the Wishbone side.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_FAIL = 2;
  localparam int STAT_LOCK = 3;
  localparam int STAT_IDMODE = 4;
  // Command cycle addresses compare on the low twelve lines only.
  localparam int CMD_ADDR_W = 12;
  localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
  localparam logic [11:0] UNLOCK2_ADDR = 12'hAAA;
  localparam logic [11:0] EXIT_ADDR = 12'h000;
  localparam logic [18:0] LOCK_ID_ADDR = 19'h0_0002;
  localparam logic [7:0] CD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CD_PROGRAM = 8'hA0;
  localparam logic [7:0] CD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CD_ID_EXIT = 8'hF0;
  localparam logic [7:0] CD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CD_LOCKOUT = 8'h40;
  localparam int BIT_LOCK_STATE = 0;
  localparam int BIT_PULSE_FAIL = 5;
  localparam int BIT_TOGGLE = 6;
  localparam logic [2:0] LEN_PROGRAM = 3'h4;
  localparam logic [2:0] LEN_SIX = 3'h6;
  localparam logic [2:0] LEN_ID = 3'h3;
  localparam logic [2:0] LEN_SINGLE = 3'h1;
  // Timing at a 100 ns clock.
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_WP_NS = 100;
  localparam int T_ACC_NS = 100;
  localparam int T_BP_US = 10;
  localparam int SYNC_STAGES = 2;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BP_CYC = (T_BP_US * 1000) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_PROGRAM = 3'h1, OP_SECTOR_ERASE = 3'h2, OP_CHIP_ERASE = 3'h3,
    OP_LOCKOUT = 3'h4, OP_ID_ENTRY = 3'h5, OP_ID_EXIT = 3'h6, OP_RESET = 3'h7
  } pfc_op_type;
endpackage : pfc_pkg

// file: pfc_cyc_if.sv
// Single bus cycle request channel between sequencer and pin engine.
`timescale 1ns/10ps
`default_nettype none
interface pfc_cyc_if;
  import pfc_pkg::*;
  logic req;
  logic we;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic done;
  logic [DATA_W-1:0] rdata;
  modport seq (output req, output we, output addr, output wdata, input done, input rdata);
  modport eng (input req, input we, input addr, input wdata, output done, output rdata);
endinterface : pfc_cyc_if
`default_nettype wire

// file: pfc_pin_engine.sv
// Pin engine: runs one read or one write cycle on the flash pins.
`timescale 1ns/10ps
`default_nettype none
module pfc_pin_engine
  import pfc_pkg::*;
#(
  parameter int WP_CYCLES = WP_CYC,
  parameter int ACC_CYCLES = ACC_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  pfc_cyc_if.eng cyc,
  output logic [ADDR_W-1:0] byte_address_lines_o,
  output logic chip_sel_n_o,
  output logic out_gate_n_o,
  output logic write_strobe_n_o,
  input wire logic [DATA_W-1:0] data_lines_i,
  output logic [DATA_W-1:0] data_lines_o,
  output logic data_lines_oe_n_o
);
  typedef enum logic [1:0] {E_IDLE = 2'b00, E_SETUP = 2'b01, E_STROBE = 2'b11,
                            E_HOLD = 2'b10} pfc_eng_st_type;
  typedef struct packed {
    pfc_eng_st_type st;
    logic [CNT_W-1:0] cnt;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic doe_n;
    logic done;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] sync1;
    logic [DATA_W-1:0] sync2;
  } pfc_eng_type;
  pfc_eng_type eng_reg;
  pfc_eng_type eng_next;
  localparam pfc_eng_type ENG_RST = '{st: E_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                      doe_n: 1'b1, default: '0};

  always_comb begin
    eng_next = eng_reg;
    eng_next.sync1 = data_lines_i;
    eng_next.sync2 = eng_reg.sync1;
    eng_next.done = 1'b0;
    case (eng_reg.st)
      E_IDLE: begin
        // The done pulse still shows the old request, so it must not restart.
        if (cyc.req && !eng_reg.done) begin
          eng_next.we = cyc.we;
          eng_next.addr = cyc.addr;
          eng_next.wdata = cyc.wdata;
          eng_next.ce_n = 1'b0;
          eng_next.doe_n = !cyc.we;
          eng_next.st = E_SETUP;
        end
      end
      E_SETUP: begin
        if (eng_reg.we) begin
          eng_next.we_n = 1'b0;
          eng_next.cnt = CNT_W'(WP_CYCLES - 1);
        end else begin
          eng_next.oe_n = 1'b0;
          eng_next.cnt = CNT_W'(ACC_CYCLES + SYNC_STAGES - 1);
        end
        eng_next.st = E_STROBE;
      end
      E_STROBE: begin
        if (eng_reg.cnt != '0) begin
          eng_next.cnt = eng_reg.cnt - 1'b1;
        end else if (eng_reg.we) begin
          // Data stays driven across the rising strobe edge where it is taken.
          eng_next.we_n = 1'b1;
          eng_next.st = E_HOLD;
        end else begin
          eng_next.rdata = eng_reg.sync2;
          eng_next.oe_n = 1'b1;
          eng_next.st = E_HOLD;
        end
      end
      E_HOLD: begin
        eng_next.ce_n = 1'b1;
        eng_next.doe_n = 1'b1;
        eng_next.done = 1'b1;
        eng_next.st = E_IDLE;
      end
      default: eng_next = ENG_RST;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eng_reg <= ENG_RST;
    end else begin
      eng_reg <= eng_next;
    end
  end

  assign byte_address_lines_o = eng_reg.addr;
  assign chip_sel_n_o = eng_reg.ce_n;
  assign out_gate_n_o = eng_reg.oe_n;
  assign write_strobe_n_o = eng_reg.we_n;
  assign data_lines_o = eng_reg.wdata;
  assign data_lines_oe_n_o = eng_reg.doe_n;
  assign cyc.done = eng_reg.done;
  assign cyc.rdata = eng_reg.rdata;

  strobe_gating_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !write_strobe_n_o |-> !chip_sel_n_o && out_gate_n_o && !data_lines_oe_n_o)
    else $error("write strobe low without select, gate high and data driven");
  data_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(write_strobe_n_o) |-> !chip_sel_n_o && !data_lines_oe_n_o &&
      $stable(data_lines_o) && $stable(byte_address_lines_o))
    else $error("data or address moved at the rising write strobe");
  read_no_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !out_gate_n_o |-> data_lines_oe_n_o && write_strobe_n_o)
    else $error("data lines driven while the output gate is low");
endmodule : pfc_pin_engine
`default_nettype wire

// file: pfc_ctrl.sv
// Wishbone controlled command sequencer for a parallel flash device.
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pfc_ctrl
  import pfc_pkg::*;
#(
  parameter int BP_CYCLES = BP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [ADDR_W-1:0] byte_address_lines_o,
  output logic chip_sel_n_o,
  output logic out_gate_n_o,
  output logic write_strobe_n_o,
  input wire logic [DATA_W-1:0] data_lines_i,
  output logic [DATA_W-1:0] data_lines_o,
  output logic data_lines_oe_n_o
);
  typedef enum logic [2:0] {S_IDLE = 3'b000, S_WRITE = 3'b001, S_WAIT = 3'b011,
                            S_POLL_A = 3'b010, S_POLL_B = 3'b110,
                            S_READ = 3'b100} pfc_st_type;
  typedef struct packed {
    logic ack;
    logic [31:0] dat_o;
    pfc_st_type st;
    pfc_op_type op;
    logic [2:0] idx;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] poll0;
    logic [CNT_W-1:0] wait_cnt;
    logic retry;
    logic done;
    logic fail;
    logic lock_seen;
    logic id_mode;
  } pfc_ctrl_type;
  pfc_ctrl_type c_reg;
  pfc_ctrl_type c_next;
  logic busy;
  logic bus_wr;

  pfc_cyc_if cyc ();

  function automatic logic [2:0] seq_len(input pfc_op_type op);
    case (op)
      OP_PROGRAM: seq_len = LEN_PROGRAM;
      OP_SECTOR_ERASE, OP_CHIP_ERASE, OP_LOCKOUT: seq_len = LEN_SIX;
      OP_ID_ENTRY, OP_ID_EXIT: seq_len = LEN_ID;
      default: seq_len = LEN_SINGLE;
    endcase
  endfunction : seq_len

  // Address and data of command step idx; upper lines are zero except where the
  // step carries a target address.
  function automatic logic [ADDR_W+DATA_W-1:0] step(input pfc_op_type op,
      input logic [2:0] idx, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] third;
    third = CD_ERASE_SETUP;
    step = {ADDR_W'(UNLOCK1_ADDR), CD_UNLOCK1};
    case (op)
      OP_PROGRAM: third = CD_PROGRAM;
      OP_ID_ENTRY: third = CD_ID_ENTRY;
      OP_ID_EXIT: third = CD_ID_EXIT;
      default: third = CD_ERASE_SETUP;
    endcase
    case (idx)
      3'h0: step = (op == OP_RESET) ? {ADDR_W'(EXIT_ADDR), CD_ID_EXIT}
                                     : {ADDR_W'(UNLOCK1_ADDR), CD_UNLOCK1};
      3'h1, 3'h4: step = {ADDR_W'(UNLOCK2_ADDR), CD_UNLOCK2};
      3'h2: step = {ADDR_W'(UNLOCK1_ADDR), third};
      3'h3: step = (op == OP_PROGRAM) ? {a, d} : {ADDR_W'(UNLOCK1_ADDR), CD_UNLOCK1};
      3'h5: begin
        case (op)
          OP_SECTOR_ERASE: step = {a, CD_SECTOR_ERASE};
          OP_LOCKOUT: step = {ADDR_W'(UNLOCK1_ADDR), CD_LOCKOUT};
          default: step = {ADDR_W'(UNLOCK1_ADDR), CD_CHIP_ERASE};
        endcase
      end
      default: step = {ADDR_W'(UNLOCK1_ADDR), CD_UNLOCK1};
    endcase
  endfunction : step

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  assign busy = (c_reg.st != S_IDLE);
  assign bus_wr = c_reg.ack && wb_cyc_i && wb_stb_i && wb_we_i;
  assign cyc.req = (c_reg.st == S_WRITE) || (c_reg.st == S_POLL_A) ||
                   (c_reg.st == S_POLL_B) || (c_reg.st == S_READ);
  assign cyc.we = (c_reg.st == S_WRITE);
  assign {cyc.addr, cyc.wdata} = (c_reg.st == S_WRITE) ?
      step(c_reg.op, c_reg.idx, c_reg.addr, c_reg.wdata) : {c_reg.addr, c_reg.wdata};

  always_comb begin
    c_next = c_reg;
    c_next.ack = wb_cyc_i && wb_stb_i && !c_reg.ack;
    c_next.dat_o = '0;
    case (wb_adr_i)
      REG_CMD: c_next.dat_o = 32'(c_reg.op);
      REG_ADDR: c_next.dat_o = 32'(c_reg.addr);
      REG_WDATA: c_next.dat_o = 32'(c_reg.wdata);
      REG_STATUS: begin
        c_next.dat_o[STAT_BUSY] = busy;
        c_next.dat_o[STAT_DONE] = c_reg.done;
        c_next.dat_o[STAT_FAIL] = c_reg.fail;
        c_next.dat_o[STAT_LOCK] = c_reg.lock_seen;
        c_next.dat_o[STAT_IDMODE] = c_reg.id_mode;
      end
      REG_RDATA: c_next.dat_o = 32'(c_reg.rdata);
      default: c_next.dat_o = '0;
    endcase
    if (bus_wr && !busy) begin
      // Target registers are frozen while a sequence runs, so polling addresses hold.
      if (wb_adr_i == REG_ADDR) begin
        c_next.addr = ADDR_W'(merge(32'(c_reg.addr), wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == REG_WDATA && wb_sel_i[0]) begin
        c_next.wdata = wb_dat_i[DATA_W-1:0];
      end
    end
    case (c_reg.st)
      S_IDLE: begin
        // Orders arrive only here, so nothing reaches the device mid-operation.
        if (bus_wr && wb_adr_i == REG_CMD && wb_sel_i[0]) begin
          c_next.op = pfc_op_type'(wb_dat_i[2:0]);
          c_next.idx = '0;
          c_next.done = 1'b0;
          c_next.fail = 1'b0;
          c_next.retry = 1'b0;
          c_next.st = (pfc_op_type'(wb_dat_i[2:0]) == OP_READ) ? S_READ : S_WRITE;
        end
      end
      S_WRITE: begin
        if (cyc.done) begin
          if (c_reg.idx == seq_len(c_reg.op) - 1'b1) begin
            case (c_reg.op)
              OP_PROGRAM, OP_SECTOR_ERASE, OP_CHIP_ERASE, OP_LOCKOUT: begin
                c_next.wait_cnt = CNT_W'(BP_CYCLES);
                c_next.st = S_WAIT;
              end
              default: begin
                c_next.id_mode = (c_reg.op == OP_ID_ENTRY);
                c_next.done = 1'b1;
                c_next.st = S_IDLE;
              end
            endcase
          end else begin
            c_next.idx = c_reg.idx + 1'b1;
          end
        end
      end
      S_WAIT: begin
        if (c_reg.wait_cnt == '0) begin
          c_next.st = S_POLL_A;
        end else begin
          c_next.wait_cnt = c_reg.wait_cnt - 1'b1;
        end
      end
      S_POLL_A: begin
        if (cyc.done) begin
          c_next.poll0 = cyc.rdata;
          c_next.st = S_POLL_B;
        end
      end
      S_POLL_B: begin
        if (cyc.done) begin
          if (cyc.rdata[BIT_TOGGLE] == c_reg.poll0[BIT_TOGGLE]) begin
            c_next.rdata = cyc.rdata;
            c_next.done = 1'b1;
            c_next.st = S_IDLE;
          end else if (cyc.rdata[BIT_PULSE_FAIL] && c_reg.retry) begin
            // Still toggling after the limit flag: give up and leave with the exit code.
            c_next.fail = 1'b1;
            c_next.op = OP_RESET;
            c_next.idx = '0;
            c_next.st = S_WRITE;
          end else begin
            // The toggle may stop as the limit flag rises, so check once more.
            c_next.retry = cyc.rdata[BIT_PULSE_FAIL];
            c_next.st = S_POLL_A;
          end
        end
      end
      S_READ: begin
        if (cyc.done) begin
          c_next.rdata = cyc.rdata;
          if (c_reg.id_mode && c_reg.addr == LOCK_ID_ADDR) begin
            c_next.lock_seen = cyc.rdata[BIT_LOCK_STATE];
          end
          c_next.done = 1'b1;
          c_next.st = S_IDLE;
        end
      end
      default: c_next.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c_reg <= '{st: S_IDLE, op: OP_READ, default: '0};
    end else begin
      c_reg <= c_next;
    end
  end

  assign wb_ack_o = c_reg.ack;
  assign wb_dat_o = c_reg.dat_o;

  pfc_pin_engine u_engine (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc(cyc.eng),
    .byte_address_lines_o(byte_address_lines_o),
    .chip_sel_n_o(chip_sel_n_o),
    .out_gate_n_o(out_gate_n_o),
    .write_strobe_n_o(write_strobe_n_o),
    .data_lines_i(data_lines_i),
    .data_lines_o(data_lines_o),
    .data_lines_oe_n_o(data_lines_oe_n_o)
  );

  busy_cmd_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
    busy && bus_wr && wb_adr_i == REG_CMD && c_reg.st != S_POLL_B |=> $stable(c_reg.op))
    else $error("command taken while an operation was in progress");
  unlock_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    c_reg.st == S_WRITE && c_reg.op != OP_RESET && (c_reg.idx == 3'h0 || c_reg.idx == 3'h1)
      |-> cyc.addr[ADDR_W-1:CMD_ADDR_W] == '0 &&
          cyc.wdata == ((c_reg.idx == 3'h0) ? CD_UNLOCK1 : CD_UNLOCK2))
    else $error("unlock cycle with wrong address or data");
  program_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    c_reg.st == S_WRITE && $past(c_reg.st) == S_WRITE && c_reg.op == OP_PROGRAM
      |-> c_reg.idx < LEN_PROGRAM)
    else $error("program sequence longer than four cycles");
  lockout_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
    c_reg.st == S_WRITE && c_reg.op == OP_LOCKOUT && c_reg.idx == 3'h5
      |-> cyc.wdata == CD_LOCKOUT && cyc.addr == ADDR_W'(UNLOCK1_ADDR))
    else $error("lockout sequence ends with the wrong code");
  poll_after_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(c_reg.st == S_WAIT) |-> ##1 (c_reg.st == S_WAIT)[*2])
    else $error("polling started without the program wait");
  done_when_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(c_reg.done) |-> c_reg.st == S_IDLE && $past(cyc.done))
    else $error("completion flagged without a finished device cycle");
endmodule : pfc_ctrl
`default_nettype wire

// file: pfc_flash_model.sv
// Behavioural model of the parallel flash device on the controller's pins.
`timescale 1ns/10ps
`default_nettype none
module pfc_flash_model
  import pfc_pkg::*;
#(
  parameter int BUSY_NS = 3000,
  parameter logic [7:0] MFR_CODE = 8'h3C,
  parameter logic [7:0] DEV_CODE = 8'hC3
) (
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic fail_i,
  output logic [DATA_W-1:0] dq_o,
  output logic drv_o
);
  logic [7:0] mem [0:524287];
  logic [ADDR_W-1:0] a_lat;
  logic [7:0] last, hold, rd;
  logic busy, erasing, tog, pfail, lim, locked, idm;
  int st;
  realtime t_end;
  wire logic wr_n = we_n_i | ce_n_i;
  initial begin
    for (int i = 0; i < 524288; i++) mem[i] = 8'hFF;
    {busy, erasing, tog, pfail, lim, locked, idm} = '0;
    st = 0;
    last = 8'h00;
  end
  task automatic wipe(input logic [18:0] lo, input int n);
    for (int i = 0; i < n; i++) begin
      if (!(locked && lo + i < 32'h0000_4000)) mem[lo + i] = 8'hFF;
    end
  endtask : wipe
  task automatic start(input logic er);
    busy = 1'b1;
    erasing = er;
    pfail = fail_i;
    t_end = $realtime + BUSY_NS;
  endtask : start
  // The later falling edge of the two strobes is the falling edge of their OR.
  always @(negedge wr_n) a_lat = addr_i;
  always @(posedge wr_n) begin
    if (lim && dq_i == CD_ID_EXIT) begin
      busy = 1'b0;
      lim = 1'b0;
    end else if (busy) st = 0;
    else case (st)
      0: begin
        if (dq_i == CD_ID_EXIT) idm = 1'b0;
        st = (a_lat[11:0] == UNLOCK1_ADDR && dq_i == CD_UNLOCK1) ? 1 : 0;
      end
      1: st = (a_lat[11:0] == UNLOCK2_ADDR && dq_i == CD_UNLOCK2) ? 2 : 0;
      4: st = (a_lat[11:0] == UNLOCK2_ADDR && dq_i == CD_UNLOCK2) ? 6 : 0;
      2: begin
        st = 0;
        if (a_lat[11:0] == UNLOCK1_ADDR) begin
          if (dq_i == CD_PROGRAM) st = 3;
          if (dq_i == CD_ERASE_SETUP) st = 5;
          if (dq_i == CD_ID_ENTRY) idm = 1'b1;
          if (dq_i == CD_ID_EXIT) idm = 1'b0;
        end
      end
      3: begin
        st = 0;
        last = dq_i;
        if (!(locked && a_lat < 19'h0_4000)) begin
          mem[a_lat] = mem[a_lat] & dq_i;
          start(1'b0);
        end
      end
      5: st = (a_lat[11:0] == UNLOCK1_ADDR && dq_i == CD_UNLOCK1) ? 4 : 0;
      default: begin
        st = 0;
        if (dq_i == CD_SECTOR_ERASE && !(locked && a_lat < 19'h0_4000)) begin
          if (a_lat < 19'h0_4000) wipe(19'h0_0000, 16384);
          else if (a_lat < 19'h0_8000) wipe({a_lat[18:13], 13'h0000}, 8192);
          else if (a_lat < 19'h1_0000) wipe(19'h0_8000, 32768);
          else wipe({a_lat[18:16], 16'h0000}, 65536);
          start(1'b1);
        end else if (a_lat[11:0] == UNLOCK1_ADDR && dq_i == CD_CHIP_ERASE) begin
          wipe(19'h0_0000, 524288);
          start(1'b1);
        end else if (a_lat[11:0] == UNLOCK1_ADDR && dq_i == CD_LOCKOUT) begin
          locked = 1'b1;
          start(1'b1);
        end
      end
    endcase
  end
  // Completion is timed here; after a failure busy holds until the host writes the exit code.
  always #100 begin
    if (busy && !lim && $realtime >= t_end) begin
      if (pfail) lim = 1'b1;
      else busy = 1'b0;
    end
  end
  always @(negedge oe_n_i) if (!ce_n_i && busy) tog = ~tog;
  always @* begin
    if (busy) rd = {erasing ? 1'b0 : ~last[7], tog, lim, 5'h00};
    else if (idm && addr_i == 19'h0_0000) rd = MFR_CODE;
    else if (idm && addr_i == 19'h0_0001) rd = DEV_CODE;
    else if (idm && addr_i == LOCK_ID_ADDR) rd = {7'h00, locked};
    else rd = mem[addr_i];
  end
  assign drv_o = !ce_n_i && !oe_n_i && we_n_i;
  always @* if (drv_o) hold = rd;
  // A released line shows the inverse of its last level so stale data never looks valid.
  assign dq_o = drv_o ? rd : ~hold;
endmodule : pfc_flash_model
`default_nettype wire

// file: pfc_tb.sv
// Self-checking bench: controller and flash model, driven over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pfc_pkg::*;
  localparam logic [7:0] MFR = 8'h3C; // Arbitrary value.
  localparam logic [7:0] DEV = 8'hC3; // Arbitrary value.
  logic clk_i, rst_i, req, we, ack, cs_n, og_n, ws_n, c_oe_n, m_drv, fail;
  logic [7:0] adr, c_dq, m_dq, dq;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [ADDR_W-1:0] fa;
  int err_total, check_count;
  assign dq = !c_oe_n ? c_dq : m_dq;
  pfc_ctrl #(.BP_CYCLES(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req),
    .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .byte_address_lines_o(fa), .chip_sel_n_o(cs_n),
    .out_gate_n_o(og_n), .write_strobe_n_o(ws_n), .data_lines_i(dq), .data_lines_o(c_dq),
    .data_lines_oe_n_o(c_oe_n));
  pfc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (.addr_i(fa), .ce_n_i(cs_n),
    .oe_n_i(og_n), .we_n_i(ws_n), .dq_i(dq), .fail_i(fail), .dq_o(m_dq), .drv_o(m_drv));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    req <= 1'b0;
    we <= 1'b0;
    if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
  endtask : bus
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus(REG_STATUS, 1'b0, 32'h0000_0000);
      n++;
    end while (q[STAT_BUSY] !== 1'b0 && n < 500);
    chk({30'h0000_0000, q[STAT_DONE], q[STAT_BUSY]}, 32'h0000_0002);
  endtask : wait_idle
  task automatic op(input pfc_op_type c, input logic [18:0] a, input logic [7:0] d);
    bus(REG_ADDR, 1'b1, {13'h0000, a});
    bus(REG_WDATA, 1'b1, {24'h00_0000, d});
    bus(REG_CMD, 1'b1, {29'h0000_0000, c});
    wait_idle();
  endtask : op
  task automatic rdf(input logic [18:0] a, input logic [7:0] exp);
    op(OP_READ, a, 8'h00);
    bus(REG_RDATA, 1'b0, 32'h0000_0000);
    chk(q, {24'h00_0000, exp});
  endtask : rdf
  task automatic id_stat(input logic [1:0] exp);
    bus(REG_STATUS, 1'b0, 32'h0000_0000);
    chk({30'h0000_0000, q[STAT_IDMODE], q[STAT_LOCK]}, {30'h0000_0000, exp});
  endtask : id_stat
  // Pin protocol watch: write strobe only with the output gate high, no bus fight.
  always @(posedge clk_i) begin
    if (!rst_i && ((ws_n === 1'b0 && og_n !== 1'b1) || (c_oe_n === 1'b0 && m_drv === 1'b1))) begin
      err_total++;
      $display("unexpected at %0t: pins %h expected %h", $time, {ws_n, og_n, c_oe_n}, 3'h5);
    end
  end
  initial begin
    #(3_000_000);
    err_total++;
    summarize();
  end
  initial begin
    rst_i = 1'b1;
    req = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0000_0000;
    fail = 1'b0;
    err_total = 0;
    check_count = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({28'h000_0000, cs_n, og_n, ws_n, c_oe_n}, 32'h0000_000F);
    bus(8'h14, 1'b1, 32'h1234_5678);
    bus(8'h14, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    rdf(19'h1_0000, 8'hFF);
    // Only lane 1 of the address register may change on this write.
    sel <= 4'h2;
    bus(REG_ADDR, 1'b1, 32'h00FF_3300);
    sel <= 4'hF;
    bus(REG_ADDR, 1'b0, 32'h0000_0000);
    chk(q, 32'h0001_3300);
    op(OP_PROGRAM, 19'h1_0000, 8'h5A);
    rdf(19'h1_0000, 8'h5A);
    op(OP_PROGRAM, 19'h1_0000, 8'h0F);
    rdf(19'h1_0000, 8'h0A);
    op(OP_PROGRAM, 19'h2_0000, 8'h33);
    // Repeat the program, then order a chip erase and new data while it runs: both are dropped.
    bus(REG_CMD, 1'b1, 32'h0000_0001);
    bus(REG_CMD, 1'b1, 32'h0000_0003);
    bus(REG_WDATA, 1'b1, 32'h0000_0000);
    wait_idle();
    bus(REG_CMD, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    bus(REG_WDATA, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0033);
    rdf(19'h0_0555, 8'hFF);
    op(OP_SECTOR_ERASE, 19'h1_8000, 8'h00);
    rdf(19'h1_0000, 8'hFF);
    rdf(19'h2_0000, 8'h33);
    op(OP_ID_ENTRY, 19'h0_0000, 8'h00);
    rdf(LOCK_ID_ADDR, 8'h00);
    rdf(19'h0_0000, MFR);
    rdf(19'h0_0001, DEV);
    id_stat(2'b10);
    op(OP_ID_EXIT, 19'h0_0000, 8'h00);
    rdf(19'h0_0000, 8'hFF);
    op(OP_PROGRAM, 19'h0_0100, 8'h12);
    op(OP_LOCKOUT, 19'h0_4000, 8'h00);
    op(OP_ID_ENTRY, 19'h0_0000, 8'h00);
    rdf(LOCK_ID_ADDR, 8'h01);
    id_stat(2'b11);
    op(OP_RESET, 19'h0_0000, 8'h00);
    op(OP_PROGRAM, 19'h0_0100, 8'h00);
    op(OP_SECTOR_ERASE, 19'h0_0000, 8'h00);
    rdf(19'h0_0100, 8'h12);
    op(OP_PROGRAM, 19'h0_4000, 8'h77);
    rdf(19'h0_4000, 8'h77);
    op(OP_CHIP_ERASE, 19'h0_4000, 8'h00);
    rdf(19'h0_4000, 8'hFF);
    rdf(19'h2_0000, 8'hFF);
    rdf(19'h0_0100, 8'h12);
    fail <= 1'b1;
    op(OP_PROGRAM, 19'h3_0000, 8'h44);
    fail <= 1'b0;
    chk({29'h0000_0000, q[2:0]}, 32'h0000_0006);
    rdf(19'h3_0000, 8'h44);
    summarize();
  end
endmodule : testbench
`default_nettype wire
